// ==== core/wave_loop_defines.svh ====
`ifndef WAVE_LOOP_DEFINES_SVH
`define WAVE_LOOP_DEFINES_SVH

// Register byte offsets
`define OFF_TIMER_COUNT     8'hc8
`define OFF_OSC_CTRL        8'hcc
`define OFF_TIMER_MATCH     8'hd0
`define OFF_IRQ_STATUS      8'hd8
`define OFF_IRQ_ENABLE      8'hdc
`define OFF_POS_INTERP      8'he0
`define OFF_LOOP_BEGIN      8'he4
`define OFF_LOOP_END_PITCH  8'he8
`define OFF_CHAN_SELECT     8'hf0
`define OFF_MISC_CTRL       8'hf4

// Oscillator control fields
`define OSC_EN_BIT          26
`define OSC_RATE_HI         25
`define OSC_RATE_LO         24
`define OSC_INIT_HI         23
`define OSC_INIT_LO         16
`define RATIO_HI            12

// Per-channel fields
`define POS_OFS_HI          31
`define POS_OFS_LO          16
`define POS_FRAC_HI         15
`define POS_FRAC_LO         4
`define POS_FM_HI           3
`define BEGIN_ADDR_HI       30
`define BEGIN_CACHE_BIT     31
`define PITCH_HI            15

// Misc control fields
`define MISC_END_IE_BIT     0
`define MISC_MID_IE_BIT     1
`define MISC_TMR_IE_BIT     2
`define MISC_TMR_CLR_BIT    3

// Prescaler masks for divide by 1, 4, 16, 64
`define PRE_MASK_DIV1       6'h00
`define PRE_MASK_DIV4       6'h03
`define PRE_MASK_DIV16      6'h0f
`define PRE_MASK_DIV64      6'h3f

`define NUM_CHANNELS        32
`define RESET_WORD          32'h0000_0000

`endif

// ==== core/wave_loop_pkg.sv ====
package wave_loop_pkg;

	// Rate select encodings of the oscillator prescaler
	typedef enum logic [1:0] {
		RATE_DIV1  = 2'h0,
		RATE_DIV4  = 2'h1,
		RATE_DIV16 = 2'h2,
		RATE_DIV64 = 2'h3
	} osc_rate_t;

	// One register bus request as seen in a cycle
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

endpackage : wave_loop_pkg

// ==== core/wave_channel_loop_lfo_regs.sv ====
// Behaviour
// (R01) Oscillator runs only while enable bit set
// (R02) Oscillator clock is tick divided 1/4/16/64
// (R03) Oscillator counts down, reloads from initial value
// (R04) Control bits 31:27 always read zero
// (R05) Measured input rate ratio readable in 12:0
// (R06) Timer counts ticks, clears on software write
// (R07) Timer match raises interrupt when enabled
// (R08) Any status bit rising raises interrupt
// (R09) Status read gives one bit per channel
// (R10) Offset at loop end sets status bit
// (R11) Offset at half loop end sets status
// (R12) Writing one clears status, zero ignored
// (R13) Per-channel enable gates address interrupt
// (R14) Channel holds current offset in 31:16
// (R15) Channel holds interpolation fraction in 15:4
// (R16) Channel holds modulation step in 3:0
// (R17) Loop begin address 30:0, bit 31 cache
// (R18) Software aligns loop begin address to sample
// (R19) Channel holds loop end offset in 31:16
// (R20) Channel holds 4.12 pitch step in 15:0
// (R21) Each tick pitch step advances offset and fraction
`timescale 1ns/1ps
`include "wave_loop_defines.svh"

module wave_channel_loop_lfo_regs (
	input  wire logic        clk_sys_i,       // System clock, 125 MHz
	input  wire logic        reset_i,         // Synchronous reset, active high
	input  wire logic [7:0]  addr_i,          // Register byte address
	input  wire logic [31:0] wdata_i,         // Write data
	input  wire logic        wr_i,            // Write strobe
	input  wire logic        rd_i,            // Read strobe
	input  wire logic        tick_48k_i,      // One-cycle sample tick
	input  wire logic [12:0] rate_ratio_i,    // Measured input rate ratio
	output logic      [31:0] rdata_o,         // Read data, cycle after strobe
	output logic             addr_irq_o,      // Pulse on new status bit
	output logic             timer_match_irq_o, // Pulse on timer match
	output logic      [7:0]  osc_count_o      // Oscillator working count
);

	// Channel count sets the per-channel arrays and generate loop; enable and status vectors are fixed at 32 bits
	localparam int NCH = `NUM_CHANNELS;

	// Address match, shared by write and read decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	wave_loop_pkg::bus_req_t req;

	// Bundle the bus so decode reads one carrier
	always_comb begin
		req.addr  = addr_i;
		req.wdata = wdata_i;
		req.wr    = wr_i;
		req.rd    = rd_i;
	end

	// Oscillator state
	logic                      osc_en_r;
	wave_loop_pkg::osc_rate_t  osc_rate_r;
	logic [7:0]                osc_init_r;
	logic [7:0]                osc_cnt_r;
	logic [5:0]                pre_cnt_r;
	logic [5:0]                pre_mask;
	logic                      osc_step;
	// Timer and interrupt state
	logic [31:0]               timer_r;
	logic [31:0]               timer_nxt;
	logic [31:0]               match_r;
	logic [31:0]               status_r;
	logic [31:0]               status_nxt;
	logic [31:0]               enable_r;
	logic [31:0]               cond_r;
	logic [31:0]               cond_now;
	logic [4:0]                chan_sel_r;
	logic                      end_ie_r;
	logic                      mid_ie_r;
	logic                      tmr_ie_r;
	logic                      timer_clr;
	// Per-channel storage, one word per channel and register
	logic [31:0]               pos_mem   [NCH];
	logic [31:0]               begin_mem [NCH];
	logic [31:0]               endp_mem  [NCH];

	// One write strobe per writable register; the timer count has none
	logic wr_osc;
	logic wr_match;
	logic wr_status;
	logic wr_enable;
	logic wr_pos;
	logic wr_begin;
	logic wr_endp;
	logic wr_sel;
	logic wr_misc;

	// Write decode
	always_comb begin
		wr_osc    = req.wr && hit(req.addr, `OFF_OSC_CTRL);
		wr_match  = req.wr && hit(req.addr, `OFF_TIMER_MATCH);
		wr_status = req.wr && hit(req.addr, `OFF_IRQ_STATUS);
		wr_enable = req.wr && hit(req.addr, `OFF_IRQ_ENABLE);
		wr_pos    = req.wr && hit(req.addr, `OFF_POS_INTERP);
		wr_begin  = req.wr && hit(req.addr, `OFF_LOOP_BEGIN);
		wr_endp   = req.wr && hit(req.addr, `OFF_LOOP_END_PITCH);
		wr_sel    = req.wr && hit(req.addr, `OFF_CHAN_SELECT);
		wr_misc   = req.wr && hit(req.addr, `OFF_MISC_CTRL);
		timer_clr = wr_misc && req.wdata[`MISC_TMR_CLR_BIT];
	end

	// Oscillator control fields; reserved bits are not stored
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			osc_en_r   <= 1'b0;
			osc_rate_r <= wave_loop_pkg::RATE_DIV1;
			osc_init_r <= 8'h00;
		end else if (wr_osc) begin
			osc_en_r   <= req.wdata[`OSC_EN_BIT];
			osc_rate_r <= wave_loop_pkg::osc_rate_t'(req.wdata[`OSC_RATE_HI:`OSC_RATE_LO]);
			osc_init_r <= req.wdata[`OSC_INIT_HI:`OSC_INIT_LO];
		end
	end

	// Prescaler mask for the selected divide ratio
	always_comb begin
		case (osc_rate_r)
			wave_loop_pkg::RATE_DIV1:  pre_mask = `PRE_MASK_DIV1;  // R02
			wave_loop_pkg::RATE_DIV4:  pre_mask = `PRE_MASK_DIV4;  // R02
			wave_loop_pkg::RATE_DIV16: pre_mask = `PRE_MASK_DIV16; // R02
			default:                   pre_mask = `PRE_MASK_DIV64; // R02
		endcase
		osc_step = osc_en_r && tick_48k_i && ((pre_cnt_r & pre_mask) == 6'h00); // R01
	end

	// Prescaler counts ticks only while running, so a restart is phase clean
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !osc_en_r) begin
			pre_cnt_r <= 6'h00; // R01
		end else if (tick_48k_i) begin
			pre_cnt_r <= pre_cnt_r + 6'h01; // R02
		end
	end

	// Working counter: down to zero, then reload; held when disabled
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			osc_cnt_r <= 8'h00;
		end else if (osc_step) begin
			if (osc_cnt_r == 8'h00) begin
				osc_cnt_r <= osc_init_r; // R03
			end else begin
				osc_cnt_r <= osc_cnt_r - 8'h01; // R03
			end
		end
	end

	// Misc control: loop interrupt enables, timer interrupt enable
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			end_ie_r <= 1'b0;
			mid_ie_r <= 1'b0;
			tmr_ie_r <= 1'b0;
		end else if (wr_misc) begin
			end_ie_r <= req.wdata[`MISC_END_IE_BIT];
			mid_ie_r <= req.wdata[`MISC_MID_IE_BIT];
			tmr_ie_r <= req.wdata[`MISC_TMR_IE_BIT];
		end
	end

	// Channel select for the per-channel window
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			chan_sel_r <= 5'h00;
		end else if (wr_sel) begin
			chan_sel_r <= req.wdata[4:0];
		end
	end

	// Sample timer; clear wins over a coincident tick
	always_comb begin
		if (timer_clr) begin
			timer_nxt = `RESET_WORD; // R06
		end else if (tick_48k_i) begin
			timer_nxt = timer_r + 32'h0000_0001; // R06
		end else begin
			timer_nxt = timer_r;
		end
	end

	// Timer register
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			timer_r <= `RESET_WORD;
		end else begin
			timer_r <= timer_nxt;
		end
	end

	// Match value, written as a whole word
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			match_r <= `RESET_WORD;
		end else if (wr_match) begin
			match_r <= req.wdata;
		end
	end

	// Match pulses once as the counter arrives at the value
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			timer_match_irq_o <= 1'b0;
		end else begin
			timer_match_irq_o <= tmr_ie_r && (timer_nxt != timer_r)
				&& (timer_nxt == match_r); // R07
		end
	end

	// Per-channel interrupt enable mask
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			enable_r <= `RESET_WORD;
		end else if (wr_enable) begin
			enable_r <= req.wdata;
		end
	end

	// Per-channel state and loop conditions
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan
			logic [27:0] acc;
			logic [15:0] ofs;
			logic [15:0] end_ofs;

			// Offset and fraction form one 16.12 accumulator
			always_comb begin
				acc = pos_mem[gi][`POS_OFS_HI:`POS_FRAC_LO]
					+ {12'h000, endp_mem[gi][`PITCH_HI:0]}; // R21
				ofs = pos_mem[gi][`POS_OFS_HI:`POS_OFS_LO]; // R14
				end_ofs = endp_mem[gi][`POS_OFS_HI:`POS_OFS_LO]; // R19
				cond_now[gi] = enable_r[gi] && ( // R13
					(end_ie_r && (ofs >= end_ofs)) || // R10
					(mid_ie_r && (ofs >= {1'b0, end_ofs[15:1]}))); // R11
			end

			// Software write wins over the engine step in the same cycle
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					pos_mem[gi] <= `RESET_WORD;
				end else if (wr_pos && (chan_sel_r == 5'(gi))) begin
					pos_mem[gi] <= req.wdata; // R14 R15 R16
				end else if (tick_48k_i) begin
					pos_mem[gi] <= {acc, pos_mem[gi][`POS_FM_HI:0]}; // R21
				end
			end

			// Loop begin and loop end/pitch words, reached through the select
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					begin_mem[gi] <= `RESET_WORD;
					endp_mem[gi]  <= `RESET_WORD;
				end else begin
					if (wr_begin && (chan_sel_r == 5'(gi))) begin
						begin_mem[gi] <= req.wdata; // R17
					end
					if (wr_endp && (chan_sel_r == 5'(gi))) begin
						endp_mem[gi] <= req.wdata; // R19 R20
					end
				end
			end
		end
	endgenerate

	// Status sets on a rising loop condition; set beats a clear
	always_comb begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt = status_r & ~req.wdata; // R12
		end
		status_nxt = status_nxt | (cond_now & ~cond_r); // R10 R11
	end

	// Edge detect keeps a held condition from refiring after a clear
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cond_r   <= `RESET_WORD;
			status_r <= `RESET_WORD;
		end else begin
			cond_r   <= cond_now;
			status_r <= status_nxt;
		end
	end

	// Request on any status bit going from zero to one
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			addr_irq_o <= 1'b0;
		end else begin
			addr_irq_o <= |(status_nxt & ~status_r); // R08
		end
	end

	// Output copy of the count; costs one cycle of lag but keeps the pin on a flop
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			osc_count_o <= 8'h00;
		end else begin
			osc_count_o <= osc_cnt_r;
		end
	end

	// Read mux; unmapped addresses return zero
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_o <= `RESET_WORD;
		end else if (!req.rd) begin
			rdata_o <= `RESET_WORD;
		end else if (hit(req.addr, `OFF_TIMER_COUNT)) begin
			rdata_o <= timer_r;
		end else if (hit(req.addr, `OFF_OSC_CTRL)) begin
			rdata_o <= {5'h00, osc_en_r, osc_rate_r, osc_init_r, // R04
				3'h0, rate_ratio_i[`RATIO_HI:0]}; // R05
		end else if (hit(req.addr, `OFF_TIMER_MATCH)) begin
			rdata_o <= match_r;
		end else if (hit(req.addr, `OFF_IRQ_STATUS)) begin
			rdata_o <= status_r; // R09
		end else if (hit(req.addr, `OFF_IRQ_ENABLE)) begin
			rdata_o <= enable_r;
		end else if (hit(req.addr, `OFF_POS_INTERP)) begin
			rdata_o <= pos_mem[chan_sel_r];
		end else if (hit(req.addr, `OFF_LOOP_BEGIN)) begin
			rdata_o <= begin_mem[chan_sel_r]; // R17
		end else if (hit(req.addr, `OFF_LOOP_END_PITCH)) begin
			rdata_o <= endp_mem[chan_sel_r];
		end else if (hit(req.addr, `OFF_CHAN_SELECT)) begin
			rdata_o <= {27'h0000000, chan_sel_r};
		end else if (hit(req.addr, `OFF_MISC_CTRL)) begin
			rdata_o <= {29'h00000000, tmr_ie_r, mid_ie_r, end_ie_r};
		end else begin
			rdata_o <= `RESET_WORD;
		end
	end

endmodule : wave_channel_loop_lfo_regs

// ==== tb/wave_loop_monitor.sv ====
`timescale 1ns/1ps
`include "wave_loop_defines.svh"

module wave_loop_monitor (
	input  wire logic        clk_sys_i,         // System clock
	input  wire logic        reset_i,           // Synchronous reset
	input  wire logic [7:0]  addr_i,            // Register address
	input  wire logic [31:0] wdata_i,           // Write data
	input  wire logic        wr_i,              // Write strobe
	input  wire logic        rd_i,              // Read strobe
	input  wire logic        tick_48k_i,        // Sample tick
	input  wire logic [12:0] rate_ratio_i,      // Measured ratio
	input  wire logic [31:0] rdata_o,           // Read data
	input  wire logic        addr_irq_o,        // Status interrupt
	input  wire logic        timer_match_irq_o, // Timer interrupt
	input  wire logic [7:0]  osc_count_o        // Oscillator count
);
	logic       en_r;   // Shadow enable
	logic [1:0] rate_r; // Shadow rate select
	logic [7:0] rld_r;  // Shadow reload value

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	// Shadow oscillator fields so checks need no internal probes
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			en_r   <= 1'b0;
			rate_r <= 2'h0;
			rld_r  <= 8'h00;
		end else if (wr_i && addr_i == `OFF_OSC_CTRL) begin
			en_r   <= wdata_i[26];
			rate_r <= wdata_i[25:24];
			rld_r  <= wdata_i[23:16];
		end
	end

	// A tick that must step the counter, and a disabled stretch
	sequence s_step; tick_48k_i && en_r && rate_r == 2'h0 && !wr_i; endsequence
	sequence s_off; !en_r [*3]; endsequence

	property p_rd_quiet; !rd_i |=> rdata_o == 32'h0; endproperty
	property p_osc_read;
		rd_i && addr_i == `OFF_OSC_CTRL |=> rdata_o[31:27] == 5'h00
			&& rdata_o[15:0] == {3'h0, $past(rate_ratio_i)}
			&& rdata_o[26:16] == {$past(en_r), $past(rate_r), $past(rld_r)};
	endproperty
	// Timer pulse is registered straight from the tick or clear edge
	property p_tmr_cause; timer_match_irq_o |-> $past(tick_48k_i) || $past(wr_i); endproperty
	property p_tmr_pulse; timer_match_irq_o |=> !timer_match_irq_o; endproperty
	property p_irq_cause; addr_irq_o |-> $past(tick_48k_i, 2) || $past(wr_i, 2); endproperty
	property p_osc_cause; $changed(osc_count_o) |-> $past(tick_48k_i, 2) || $past(wr_i, 2); endproperty
	property p_osc_hold; s_off |-> $stable(osc_count_o); endproperty
	// Output lags the counter by one, so the new value shows two edges on
	property p_osc_step;
		s_step |=> ##1 osc_count_o == (($past(osc_count_o) == 8'h00) ?
			$past(rld_r, 2) : $past(osc_count_o) - 8'h01);
	endproperty

	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
	a_osc_read: assert property (p_osc_read) else $error("osc ctrl readback");
	a_tmr_cause: assert property (p_tmr_cause) else $error("timer irq cause");
	a_tmr_pulse: assert property (p_tmr_pulse) else $error("timer irq width");
	a_irq_cause: assert property (p_irq_cause) else $error("status irq cause");
	a_osc_cause: assert property (p_osc_cause) else $error("osc moved off tick");
	a_osc_hold: assert property (p_osc_hold) else $error("osc moved disabled");
	a_osc_step: assert property (p_osc_step) else $error("osc step value");
endmodule : wave_loop_monitor

bind wave_channel_loop_lfo_regs wave_loop_monitor mon (
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .tick_48k_i(tick_48k_i), .rate_ratio_i(rate_ratio_i),
	.rdata_o(rdata_o), .addr_irq_o(addr_irq_o), .timer_match_irq_o(timer_match_irq_o),
	.osc_count_o(osc_count_o));

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "wave_loop_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end

module tb;
	logic        clk_sys_i    = 1'b0;
	logic        reset_i      = 1'b1;
	logic [7:0]  addr_i       = 8'h00;
	logic [31:0] wdata_i      = 32'h0;
	logic        wr_i         = 1'b0;
	logic        rd_i         = 1'b0;
	logic        tick_48k_i   = 1'b0;
	logic [12:0] rate_ratio_i = 13'h0;
	logic [31:0] rdata_o;
	logic        addr_irq_o;
	logic        timer_match_irq_o;
	logic [7:0]  osc_count_o;
	int          bad_count = 0, samples_checked = 0, a_cnt = 0, t_cnt = 0;
	int          pre = 0, dv = 1, tc = 0, n, k;
	logic        oen = 1'b0;
	logic [7:0]  cnt = 8'h00, rld;
	logic [27:0] pos = 28'h0;
	logic [15:0] pitch = 16'h0;
	logic [31:0] d, v, m;
	logic [4:0]  ch;
	logic [7:0]  offs [5] = '{8'hd0, 8'hd8, 8'hdc, 8'hc8, 8'h10};

	always #4 clk_sys_i = ~clk_sys_i;

	wave_channel_loop_lfo_regs DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.tick_48k_i(tick_48k_i), .rate_ratio_i(rate_ratio_i), .rdata_o(rdata_o),
		.addr_irq_o(addr_irq_o), .timer_match_irq_o(timer_match_irq_o),
		.osc_count_o(osc_count_o));

	// Count interrupt pulses so repeats and misses both show
	always @(posedge clk_sys_i) begin
		if (addr_irq_o === 1'b1) a_cnt++;
		if (timer_match_irq_o === 1'b1) t_cnt++;
	end

	function automatic logic [7:0] osc_next(input logic [7:0] c, input logic [7:0] r);
		return (c == 8'h00) ? r : c - 8'h01;
	endfunction : osc_next

	task automatic test_done();
		$display("Checks %0d, errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_sys_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= x;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr

	// Ratio input changes with every read to exercise the live field
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		@(posedge clk_sys_i);
		rd_i         <= 1'b1;
		addr_i       <= a;
		rate_ratio_i <= 13'($urandom);
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 x = rdata_o;
	endtask : rd

	// One tick, with the reference model stepped alongside
	task automatic tk();
		@(posedge clk_sys_i);
		tick_48k_i <= 1'b1;
		@(posedge clk_sys_i);
		tick_48k_i <= 1'b0;
		pos = pos + {12'h000, pitch};
		tc++;
		if (oen) begin
			if (pre % dv == 0) cnt = osc_next(cnt, rld);
			pre++;
		end
	endtask : tk

	task automatic tick_to(input logic [15:0] lim);
		n = 0;
		while (pos[27:12] < lim && n < 20) begin
			tk();
			n++;
		end
		if (pos[27:12] < lim) begin
			bad_count++;
			test_done();
		end
	endtask : tick_to

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		test_done();
	end

	initial begin
		void'($urandom(65));
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// Reset values, unmapped read, reserved bits
		rd(`OFF_OSC_CTRL, v);
		`CHK(v, {19'h0, rate_ratio_i})
		foreach (offs[i]) begin
			rd(offs[i], v);
			`CHK(v, 32'h0)
		end
		wr(`OFF_OSC_CTRL, 32'hffff_ffff);
		rd(`OFF_OSC_CTRL, v);
		`CHK(v, {16'h07ff, 3'h0, rate_ratio_i})
		// Every rate, random reload and tick count
		for (int r = 0; r < 4; r++) begin
			wr(`OFF_OSC_CTRL, 32'h0);
			oen = 1'b0;
			tk();
			tk();
			repeat (3) @(posedge clk_sys_i);
			`CHK(osc_count_o, cnt)
			rld = 8'($urandom_range(1, 9));
			wr(`OFF_OSC_CTRL, {5'h1f, 1'b1, 2'(r), rld, 16'hffff});
			oen = 1'b1;
			pre = 0;
			dv = 1 << (2 * r);
			k = $urandom_range(1, 2 * dv + 2);
			repeat (k) tk();
			repeat (3) @(posedge clk_sys_i);
			`CHK(osc_count_o, cnt)
		end
		wr(`OFF_OSC_CTRL, 32'h0);
		oen = 1'b0;
		// Timer: count, clear, match with and without enable
		rd(`OFF_TIMER_COUNT, v);
		`CHK(v, 32'(tc))
		wr(`OFF_TIMER_MATCH, 32'h5);
		wr(`OFF_MISC_CTRL, 32'hc);
		tc = 0;
		repeat (6) tk();
		repeat (3) @(posedge clk_sys_i);
		`CHK(t_cnt, 1)
		rd(`OFF_TIMER_COUNT, v);
		`CHK(v, 32'(tc))
		wr(`OFF_MISC_CTRL, 32'h8);
		repeat (6) tk();
		repeat (3) @(posedge clk_sys_i);
		`CHK(t_cnt, 1)
		// Channel loop registers on a random channel
		ch = 5'($urandom);
		m = 32'h1 << ch;
		pitch = 16'h1000 + 16'($urandom_range(0, 4095));
		d = $urandom & 32'hffff_fffc;
		wr(`OFF_CHAN_SELECT, {27'h0, ch});
		wr(`OFF_LOOP_END_PITCH, {16'h0008, pitch});
		wr(`OFF_POS_INTERP, 32'h0000_000a);
		pos = 28'h0;
		wr(`OFF_LOOP_BEGIN, d);
		rd(`OFF_LOOP_BEGIN, v);
		`CHK(v, d)
		rd(`OFF_LOOP_END_PITCH, v);
		`CHK(v, {16'h0008, pitch})
		// Mid-loop reached while the channel is masked
		wr(`OFF_MISC_CTRL, 32'h2);
		tick_to(16'h4);
		rd(`OFF_IRQ_STATUS, v);
		`CHK(v, 32'h0)
		wr(`OFF_IRQ_ENABLE, m);
		rd(`OFF_IRQ_STATUS, v);
		`CHK(v, m)
		`CHK(a_cnt, 1)
		rd(`OFF_POS_INTERP, v);
		`CHK(v, {pos, 4'ha})
		// Zero leaves the bit, one clears it and a held condition stays cleared
		wr(`OFF_IRQ_STATUS, ~m);
		rd(`OFF_IRQ_STATUS, v);
		`CHK(v, m)
		wr(`OFF_IRQ_STATUS, m);
		rd(`OFF_IRQ_STATUS, v);
		`CHK(v, 32'h0)
		wr(`OFF_MISC_CTRL, 32'h1);
		tick_to(16'h8);
		rd(`OFF_IRQ_STATUS, v);
		`CHK(v, m)
		`CHK(a_cnt, 2)
		test_done();
	end
endmodule : tb
